// File: logic/flash_guard_regs.vh
// Purpose: constants for the flash write-protection block
// Assumes: included by bare name
// Notes: commands arrive as decoded bytes with a bit count
`ifndef FLASH_GUARD_REGS_VH
`define FLASH_GUARD_REGS_VH
`define CMD_SET_WRITE_LATCH 8'h06
`define CMD_CLR_WRITE_LATCH 8'h04
`define CMD_WRITE_STATUS 8'h01
`define CMD_PAGE_PROGRAM 8'h02
`define CMD_SECTOR_ERASE 8'h20
`define CMD_BLOCK_ERASE 8'hd8
`define CMD_CHIP_ERASE 8'hc7
`define CMD_DEEP_POWER_DOWN 8'hb9
`define CMD_RELEASE_POWER_DOWN 8'hab
`define CMD_SOFT_RESET 8'h99
`define CMD_ENTER_SECURE 8'hb1
`define CMD_EXIT_SECURE 8'hc1
`define CMD_WRITE_SECURITY 8'h2f
`define BLOCK_ADDR_LSB 16
`define BLOCK_ADDR_MSB 24
`define LAST_BLOCK 9'h1ff
`define LEVEL_ALL 4'ha
`define OTP_SERIAL_LAST 9'h00f
`define OTP_ADDR_MSB 8
`define SEC_FACTORY_BIT 0
`define SEC_CUSTOMER_BIT 1
`define STATE_STANDBY 2'h0
`define STATE_ACTIVE 2'h1
`define STATE_POWER_DOWN 2'h2
`endif

// File: logic/block_range_decode.v
// Purpose: decide whether a 64K block lies in the read-only area
// Assumes: level and top/bottom select from the status bits
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_regs.vh"
module block_range_decode
(
  input wire [3:0] i_level,
  input wire i_from_bottom,
  input wire [8:0] i_block,
  output reg o_locked
);
  reg [9:0] span;
  // blocks covered: 2^(level-1), zero at level 0
  always @*
  begin
    span = 10'h000;
    if (i_level != 4'h0)
      span = 10'h001 << (i_level - 4'h1);
    if (i_level >= `LEVEL_ALL)
      o_locked = 1'b1;
    else if (i_level == 4'h0)
      o_locked = 1'b0;
    else if (i_from_bottom)
      o_locked = ({1'b0, i_block} < span);
    else
      o_locked = ({1'b0, i_block} >= (10'h200 - span));
  end
endmodule // block_range_decode
`default_nettype wire

// File: logic/flash_write_guard.v
// Purpose: write-protection guard of a serial NOR flash command path
// Assumes: host front end hands over decoded command, address, bit count
// Notes: grants go to the array engine as one-cycle pulses
// Behaviour
// - reset puts the command state machine in standby, nothing pending.
// - accept a command only if its bit count is whole bytes.
// - data-changing commands ending off a byte boundary are rejected.
// - data changes refused while the write enable latch is clear.
// - memory changes only after a complete valid command finishes.
// - in deep power-down only release, signature and soft reset pass.
// - level bits and top/bottom select mark a read-only area.
// - program and erase both rejected inside the protected area.
// - protection unit is a 64K block, 512 blocks in all.
// - top select 0: level n protects top 2^(n-1) blocks.
// - top select 1: level n protects bottom 2^(n-1) blocks.
// - levels 10 to 15 protect all 512 blocks.
// - hardware mode: protect pin blocks level and status-protect bit writes.
// - protect pin is active low.
// - quad lanes or quad command mode disable hardware mode.
// - a 4K-bit one-time area holds a serial number.
// - security bit 0 shows the factory lock.
// - enter secure, program, exit secure; mode tracked.
// - write-security command sets security bit 1.
// - locks clear only at reset; locked one-time content never altered.
// - secure mode refuses all main array accesses.
// - offsets 000-00f serial number, 010-1ff customer region.
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_regs.vh"
module flash_write_guard
(
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_cmd_start,
  input wire i_cmd_end,
  input wire [7:0] i_cmd_code,
  input wire [31:0] i_cmd_addr,
  input wire [15:0] i_cmd_bits,
  input wire [7:0] i_status_data,
  input wire i_write_protect_pin_n,
  input wire i_quad_enable,
  input wire i_quad_command_mode,
  input wire i_factory_lock,
  output reg o_program_go,
  output reg o_erase_go,
  output reg o_otp_program_go,
  output reg o_status_write_go,
  output reg o_cmd_reject,
  output reg o_write_enable_latch,
  output reg [3:0] o_protect_level_bits,
  output reg o_top_bottom,
  output reg o_status_protect,
  output reg o_secure_mode,
  output reg [1:0] o_security_bits,
  output reg o_power_down,
  output reg o_hardware_protect_mode,
  output reg [1:0] o_state
);
  // ----------------------------------------------------------
  // protection decode
  // ----------------------------------------------------------
  wire block_locked;
  wire [8:0] target_block;
  // 64K blocks: address bits 24 to 16 pick one of 512
  assign target_block = i_cmd_addr[`BLOCK_ADDR_MSB:`BLOCK_ADDR_LSB];
  block_range_decode u_range
  (
    .i_level(o_protect_level_bits),
    .i_from_bottom(o_top_bottom),
    .i_block(target_block),
    .o_locked(block_locked)
  );
  // hardware mode: pin low, status-protect set, no quad use
  // in quad use the pin carries data, so it cannot guard anything
  wire hw_mode;
  assign hw_mode = o_status_protect & ~i_write_protect_pin_n
    & ~i_quad_enable & ~i_quad_command_mode;
  // ----------------------------------------------------------
  // command classification
  // ----------------------------------------------------------
  wire whole_bytes;
  wire is_program;
  wire is_erase;
  wire is_chip_erase;
  wire is_status_wr;
  wire is_sec_wr;
  wire pd_allowed;
  wire otp_hit_serial;
  wire otp_locked;
  // select rising mid-byte leaves a count that is not a multiple of 8
  assign whole_bytes = (i_cmd_bits[2:0] == 3'h0) && (i_cmd_bits != 16'h0000);
  assign is_program = (i_cmd_code == `CMD_PAGE_PROGRAM);
  assign is_chip_erase = (i_cmd_code == `CMD_CHIP_ERASE);
  assign is_erase = (i_cmd_code == `CMD_SECTOR_ERASE) || (i_cmd_code == `CMD_BLOCK_ERASE)
    || is_chip_erase;
  assign is_status_wr = (i_cmd_code == `CMD_WRITE_STATUS);
  assign is_sec_wr = (i_cmd_code == `CMD_WRITE_SECURITY);
  // release also answers the signature read; soft reset always passes
  assign pd_allowed = (i_cmd_code == `CMD_RELEASE_POWER_DOWN)
    || (i_cmd_code == `CMD_SOFT_RESET);
  // one-time area offsets 000 to 00f hold the serial number
  assign otp_hit_serial = (i_cmd_addr[`OTP_ADDR_MSB:0] <= `OTP_SERIAL_LAST);
  // serial number always locked, factory lock set or not; customer lock guards the rest
  assign otp_locked = otp_hit_serial ? (o_security_bits[`SEC_FACTORY_BIT] | 1'b1)
    : o_security_bits[`SEC_CUSTOMER_BIT];
  // any protected block makes chip erase fail
  wire level_nonzero;
  assign level_nonzero = (o_protect_level_bits != 4'h0);
  // ----------------------------------------------------------
  // evaluation at command end
  // ----------------------------------------------------------
  reg nxt_program;
  reg nxt_erase;
  reg nxt_otp;
  reg nxt_status;
  reg nxt_reject;
  reg nxt_latch;
  reg nxt_secure;
  reg nxt_cust_lock;
  reg nxt_pd;
  reg data_cmd;
  // one verdict per end pulse: a go pulse, a reject or a level change
  // length, power-down and latch checks come first; a failure changes nothing
  always @*
  begin
    nxt_program = 1'b0;
    nxt_erase = 1'b0;
    nxt_otp = 1'b0;
    nxt_status = 1'b0;
    nxt_reject = 1'b0;
    nxt_latch = o_write_enable_latch;
    nxt_secure = o_secure_mode;
    nxt_cust_lock = o_security_bits[`SEC_CUSTOMER_BIT];
    nxt_pd = o_power_down;
    data_cmd = is_program | is_erase | is_status_wr | is_sec_wr;
    if (i_cmd_end)
    begin
      if (!whole_bytes)
        nxt_reject = 1'b1;
      else if (o_power_down && !pd_allowed)
        nxt_reject = 1'b1;
      else if (data_cmd && !o_write_enable_latch)
        nxt_reject = 1'b1;
      else
      begin
        case (i_cmd_code)
          `CMD_SET_WRITE_LATCH: nxt_latch = 1'b1;
          `CMD_CLR_WRITE_LATCH: nxt_latch = 1'b0;
          `CMD_DEEP_POWER_DOWN: nxt_pd = 1'b1;
          `CMD_RELEASE_POWER_DOWN: nxt_pd = 1'b0;
          `CMD_SOFT_RESET:
          begin
            nxt_pd = 1'b0;
            nxt_latch = 1'b0;
            nxt_secure = 1'b0;
          end
          `CMD_ENTER_SECURE: nxt_secure = 1'b1;
          `CMD_EXIT_SECURE: nxt_secure = 1'b0;
          default: nxt_latch = o_write_enable_latch;
        endcase
        if (is_sec_wr)
          nxt_cust_lock = 1'b1;
        if (is_status_wr)
          nxt_status = 1'b1;
        if (is_program && o_secure_mode)
        begin
          if (otp_locked)
            nxt_reject = 1'b1;
          else
            nxt_otp = 1'b1;
        end
        else if (is_erase && o_secure_mode)
          nxt_reject = 1'b1;
        else if (is_program || is_erase)
        begin
          if (block_locked || (is_chip_erase && level_nonzero))
            nxt_reject = 1'b1;
          else if (is_program)
            nxt_program = 1'b1;
          else
            nxt_erase = 1'b1;
        end
        if (data_cmd)
          nxt_latch = 1'b0;
      end
    end
  end
  // ----------------------------------------------------------
  // status bits with hardware protect
  // ----------------------------------------------------------
  reg [3:0] nxt_level;
  reg nxt_tb;
  reg nxt_srp;
  // hardware mode freezes level and protect bit; top/bottom stays writable
  always @*
  begin
    nxt_level = o_protect_level_bits;
    nxt_tb = o_top_bottom;
    nxt_srp = o_status_protect;
    if (nxt_status)
    begin
      nxt_tb = i_status_data[6];
      if (!hw_mode)
      begin
        nxt_level = i_status_data[5:2];
        nxt_srp = i_status_data[7];
      end
    end
  end
  // ----------------------------------------------------------
  // sticky lock bits
  // ----------------------------------------------------------
  // bit 0 is set by the factory pin, bit 1 by the write-security command
  // a lock only ever sets, so no command can reopen a locked area
  wire [1:0] lock_set;
  wire [1:0] nxt_locks;
  assign lock_set = {nxt_cust_lock, i_factory_lock};
  genvar lk;
  generate
    for (lk = 0; lk < 2; lk = lk + 1)
    begin : g_lock
      assign nxt_locks[lk] = o_security_bits[lk] | lock_set[lk];
    end
  endgenerate
  // ----------------------------------------------------------
  // go and reject pulses
  // ----------------------------------------------------------
  // each pulse stands one cycle; a refused command raises only reject
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_program_go <= 1'b0;
      o_erase_go <= 1'b0;
      o_otp_program_go <= 1'b0;
      o_status_write_go <= 1'b0;
      o_cmd_reject <= 1'b0;
    end
    else
    begin
      o_program_go <= nxt_program;
      o_erase_go <= nxt_erase;
      o_otp_program_go <= nxt_otp;
      o_status_write_go <= nxt_status;
      o_cmd_reject <= nxt_reject;
    end
  end
  // ----------------------------------------------------------
  // latch, status and mode levels
  // ----------------------------------------------------------
  // levels hold until a command past the length, power-down and latch checks changes them; hardware mode follows the pins and the
  // status-protect bit, and the factory pin sets lock bit 0
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_write_enable_latch <= 1'b0;
      o_protect_level_bits <= 4'h0;
      o_top_bottom <= 1'b0;
      o_status_protect <= 1'b0;
      o_secure_mode <= 1'b0;
      o_security_bits <= 2'h0;
      o_power_down <= 1'b0;
      o_hardware_protect_mode <= 1'b0;
    end
    else
    begin
      o_write_enable_latch <= nxt_latch;
      o_protect_level_bits <= nxt_level;
      o_top_bottom <= nxt_tb;
      o_status_protect <= nxt_srp;
      o_secure_mode <= nxt_secure;
      o_security_bits <= nxt_locks;
      o_power_down <= nxt_pd;
      o_hardware_protect_mode <= hw_mode;
    end
  end
  // ----------------------------------------------------------
  // command state machine
  // ----------------------------------------------------------
  // standby between commands; a start while asleep waits in power-down
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_state <= `STATE_STANDBY;
    else
    begin
      case (o_state)
        `STATE_STANDBY:
          if (i_cmd_start)
            o_state <= o_power_down ? `STATE_POWER_DOWN : `STATE_ACTIVE;
        `STATE_ACTIVE:
          if (i_cmd_end)
            o_state <= `STATE_STANDBY;
        `STATE_POWER_DOWN:
          if (i_cmd_end)
            o_state <= `STATE_STANDBY;
        default: o_state <= `STATE_STANDBY;
      endcase
    end
  end
endmodule // flash_write_guard
`default_nettype wire

// File: verification/flash_guard_monitor.sv
// Purpose: port checks for the flash write guard
// Assumes: one clock, async active-low reset
// Notes: bound from the testbench
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_regs.vh"
module flash_guard_monitor
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_cmd_end,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_bits,
  input wire logic o_program_go,
  input wire logic o_erase_go,
  input wire logic o_cmd_reject,
  input wire logic o_write_enable_latch,
  input wire logic [3:0] o_protect_level_bits,
  input wire logic o_secure_mode,
  input wire logic [1:0] o_security_bits,
  input wire logic o_power_down,
  input wire logic o_hardware_protect_mode,
  input wire logic [1:0] o_state
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // array pulses and a command taken while asleep
  wire logic arr = o_program_go | o_erase_go;
  wire logic pd_cmd = i_cmd_end && o_power_down && i_cmd_code != `CMD_SOFT_RESET
    && i_cmd_code != `CMD_RELEASE_POWER_DOWN;
  sequence bad_len;
    i_cmd_end && (i_cmd_bits[2:0] != 3'h0 || i_cmd_bits == 16'h0);
  endsequence
  sequence refused;
    o_cmd_reject && !arr;
  endsequence
  a_len_reject: assert property (bad_len |=> refused)
    else $error("bad length not rejected");
  a_latch_needed: assert property (i_cmd_end && !o_write_enable_latch |=> !arr)
    else $error("array change without latch");
  a_pd_blocks: assert property (pd_cmd |=> refused and o_power_down)
    else $error("command passed in power-down");
  a_all_locked: assert property (i_cmd_end && o_protect_level_bits >= `LEVEL_ALL |=> !arr)
    else $error("array change at full protect");
  a_hw_freeze: assert property (i_cmd_end && o_hardware_protect_mode
    |=> $stable(o_protect_level_bits))
    else $error("level changed in hardware mode");
  a_locks_stay: assert property (!$fell(o_security_bits[0]) && !$fell(o_security_bits[1]))
    else $error("lock bit cleared");
  a_secure_blocks: assert property (i_cmd_end && o_secure_mode |=> !arr)
    else $error("array access in secure mode");
  a_wake_standby: assert property ($rose(i_rstn) |-> o_state == `STATE_STANDBY
    && !o_write_enable_latch)
    else $error("not standby after reset");
endmodule // flash_guard_monitor
`default_nettype wire

// File: verification/flash_host_model.sv
// Purpose: host side issuing decoded flash commands
// Assumes: called from the bench, one command per call
// Notes: code, address and status fields show an inverted pattern between commands
`timescale 1ns/10ps
`default_nettype none
module flash_host_model
(
  input wire logic i_core_clk,
  output logic o_start,
  output logic o_end,
  output logic [7:0] o_code,
  output logic [31:0] o_addr,
  output logic [15:0] o_bits,
  output logic [7:0] o_sdat
);
  initial {o_start, o_end, o_code, o_addr, o_bits, o_sdat} = '0;
  // select falls, then rises with all fields valid for one edge
  task send(input [7:0] c, input [31:0] a, input [15:0] n, input [7:0] s);
    @(posedge i_core_clk) #1 o_start = 1'b1;
    @(posedge i_core_clk) #1 {o_start, o_end, o_code, o_addr, o_bits, o_sdat} = {2'b01, c, a, n, s};
    @(posedge i_core_clk) #1 {o_end, o_code, o_addr, o_sdat} = {1'b0, ~c, ~a, ~s};
  endtask
endmodule // flash_host_model
`default_nettype wire

// File: verification/testbench.sv
// Purpose: self-checking bench for the flash write guard
// Assumes: answers one cycle after each end pulse
// Notes: table rows first, then power-down and secure mode, hardware mode, locks, reset
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_regs.vh"
`define CHK(nm, e, g) comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end
module testbench;
  typedef struct packed {bit w; logic [7:0] c; logic [31:0] a; logic [15:0] n;
    logic [7:0] s; logic [4:0] e;} row_t;
  logic i_core_clk = 0, i_rstn = 0, wpn = 1, qe = 0, qm = 0, flock = 0;
  wire logic st, en, pg, eg, og, sg, rj, write_enable_latch, tbs, hw, srp, sec, pd;
  wire logic [7:0] cd, sd;
  wire logic [31:0] ad;
  wire logic [15:0] nb;
  wire logic [3:0] lvl;
  wire logic [1:0] sb, stt;
  int mismatches = 0, comparisons = 0, cyc = 0;
  // latch first?, code, address, bit count, status, {prog,erase,otp,status,reject}
  row_t rows [0:32] = '{'{1,'h02,0,'h28,0,'h10}, '{0,'h02,0,'h28,0,'h01},
    '{1,'h02,0,'h29,0,'h01}, '{0,'h06,0,'hc,0,'h01}, '{1,'h01,0,'h10,'h04,'h02},
    '{1,'h20,'h1ff0000,'h28,0,'h01}, '{1,'h20,'h1fe0000,'h28,0,'h08},
    '{1,'h01,0,'h10,'h44,'h02}, '{1,'hd8,0,'h28,0,'h01}, '{1,'hd8,'h10000,'h28,0,'h08},
    '{1,'h01,0,'h10,'h24,'h02}, '{1,'h02,'hff0000,'h28,0,'h10},
    '{1,'h02,'h1000000,'h28,0,'h01}, '{1,'h01,0,'h10,'h28,'h02}, '{1,'h02,0,'h28,0,'h01},
    '{1,'hc7,0,'h8,0,'h01}, '{1,'h01,0,'h10,0,'h02}, '{1,'hc7,0,'h8,0,'h08},
    '{0,'hb1,0,'h8,0,0}, '{1,'h02,'h10,'h28,0,'h04}, '{1,'h02,'hf,'h28,0,'h01},
    '{1,'h20,0,'h28,0,'h01}, '{1,'h2f,0,'h8,0,0}, '{1,'h02,'h10,'h28,0,'h01},
    '{0,'hc1,0,'h8,0,0}, '{0,'hb9,0,'h8,0,0}, '{0,'h06,0,'h8,0,'h01}, '{0,'hab,0,'h8,0,0},
    '{1,'h02,0,'h28,0,'h10}, '{1,'h04,0,'h8,0,0}, '{0,'h02,0,'h28,0,'h01},
    '{1,'h99,0,'h8,0,0}, '{0,'h02,0,'h28,0,'h01}};
  flash_host_model host
  (
    .i_core_clk(i_core_clk), .o_start(st), .o_end(en), .o_code(cd), .o_addr(ad),
    .o_bits(nb), .o_sdat(sd)
  );
  flash_write_guard uut
  (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_cmd_start(st), .i_cmd_end(en),
    .i_cmd_code(cd), .i_cmd_addr(ad), .i_cmd_bits(nb), .i_status_data(sd),
    .i_write_protect_pin_n(wpn), .i_quad_enable(qe), .i_quad_command_mode(qm),
    .i_factory_lock(flock), .o_program_go(pg), .o_erase_go(eg), .o_otp_program_go(og),
    .o_status_write_go(sg), .o_cmd_reject(rj), .o_write_enable_latch(write_enable_latch),
    .o_protect_level_bits(lvl), .o_top_bottom(tbs), .o_status_protect(srp),
    .o_secure_mode(sec), .o_security_bits(sb), .o_power_down(pd),
    .o_hardware_protect_mode(hw), .o_state(stt)
  );
  always #4 i_core_clk = ~i_core_clk;
  // cycle ceiling against a hang
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 1500)
    begin
      mismatches++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge i_core_clk);
    #1 i_rstn = 1;
    foreach (rows[i])
    begin
      if (rows[i].w) host.send(`CMD_SET_WRITE_LATCH, 0, 16'h8, 0);
      host.send(rows[i].c, rows[i].a, rows[i].n, rows[i].s);
      `CHK("answer", rows[i].e, {pg, eg, og, sg, rj})
    end
    `CHK("customer lock", 2'h2, sb)
    $display("table rows done");
    // asleep: release wakes, enter secure is ignored
    host.send(`CMD_DEEP_POWER_DOWN, 0, 16'h8, 0);
    `CHK("asleep", 1'b1, pd)
    host.send(`CMD_ENTER_SECURE, 0, 16'h8, 0);
    `CHK("secure while asleep", 1'b0, sec)
    host.send(`CMD_RELEASE_POWER_DOWN, 0, 16'h8, 0);
    `CHK("awake", 1'b0, pd)
    host.send(`CMD_ENTER_SECURE, 0, 16'h8, 0);
    `CHK("secure entered", 1'b1, sec)
    host.send(`CMD_EXIT_SECURE, 0, 16'h8, 0);
    `CHK("secure left", 1'b0, sec)
    $display("power-down and secure mode done");
    // protect bit set with the pin high: no hardware mode yet
    host.send(`CMD_SET_WRITE_LATCH, 0, 16'h8, 0);
    host.send(`CMD_WRITE_STATUS, 0, 16'h10, 8'h80);
    `CHK("status protect", 1'b1, srp)
    `CHK("pin high", 1'b0, hw)
    // pin low: level and protect bit frozen, top/bottom still written
    wpn = 0;
    host.send(`CMD_SET_WRITE_LATCH, 0, 16'h8, 0);
    host.send(`CMD_WRITE_STATUS, 0, 16'h10, 8'h48);
    `CHK("hw mode", 1'b1, hw)
    `CHK("frozen level", 4'h0, lvl)
    `CHK("frozen protect", 1'b1, srp)
    `CHK("top select", 1'b1, tbs)
    qe = 1;
    host.send(`CMD_SET_WRITE_LATCH, 0, 16'h8, 0);
    host.send(`CMD_WRITE_STATUS, 0, 16'h10, 8'h88);
    `CHK("quad frees level", 4'h2, lvl)
    `CHK("quad hw mode", 1'b0, hw)
    qe = 0;
    qm = 1;
    host.send(`CMD_SET_WRITE_LATCH, 0, 16'h8, 0);
    host.send(`CMD_WRITE_STATUS, 0, 16'h10, 8'h84);
    `CHK("quad command frees level", 4'h1, lvl)
    qm = 0;
    $display("hardware mode done");
    flock = 1;
    repeat (2) @(posedge i_core_clk);
    #1 flock = 0;
    repeat (2) @(posedge i_core_clk);
    #1 `CHK("factory lock", 1'b1, sb[0])
    i_rstn = 0;
    repeat (2) @(posedge i_core_clk);
    #1 i_rstn = 1;
    `CHK("standby", 2'h0, stt)
    `CHK("latch", 1'b0, write_enable_latch)
    `CHK("level after reset", 4'h0, lvl)
    host.send(`CMD_SET_WRITE_LATCH, 0, 16'h8, 0);
    `CHK("latch after reset", 1'b1, write_enable_latch)
    $display("locks and reset done");
    tally_and_finish;
  end
endmodule // testbench
bind flash_write_guard flash_guard_monitor mon
(
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_cmd_end(i_cmd_end), .i_cmd_code(i_cmd_code),
  .i_cmd_bits(i_cmd_bits), .o_program_go(o_program_go), .o_erase_go(o_erase_go),
  .o_cmd_reject(o_cmd_reject), .o_write_enable_latch(o_write_enable_latch),
  .o_protect_level_bits(o_protect_level_bits), .o_secure_mode(o_secure_mode),
  .o_security_bits(o_security_bits), .o_power_down(o_power_down),
  .o_hardware_protect_mode(o_hardware_protect_mode), .o_state(o_state)
);
`default_nettype wire
